/* File: logic/ecp_pkg.sv */
// constants shared by the capture/compare/pwm control block
// assumes a 32-bit apb slave at byte addresses below 0x20
package ecp_pkg;
    // register byte offsets
    localparam logic [7:0] ECP_OFF_CTRL = 8'h00;
    localparam logic [7:0] ECP_OFF_DUTY = 8'h04;
    localparam logic [7:0] ECP_OFF_CAPT = 8'h08;
    localparam logic [7:0] ECP_OFF_STAT = 8'h0c;
    localparam logic [7:0] ECP_OFF_DEAD = 8'h10;
    localparam logic [7:0] ECP_OFF_PER = 8'h14;
    // control register fields
    localparam int ECP_STEER_HI = 7;
    localparam int ECP_STEER_LO = 6;
    localparam int ECP_DUTY_HI = 5;
    localparam int ECP_DUTY_LO = 4;
    localparam int ECP_MODE_HI = 3;
    localparam int ECP_MODE_LO = 0;
    // status register fields
    localparam int ECP_STAT_FLAG = 0;
    localparam int ECP_STAT_IEN = 1;
    // reset values
    localparam logic [7:0] ECP_CTRL_RST = 8'h00;
    localparam logic [7:0] ECP_DUTY_RST = 8'h00;
    localparam logic [7:0] ECP_PER_RST = 8'hff;
    localparam logic [6:0] ECP_DEAD_RST = 7'h00;
    localparam logic [15:0] ECP_CAPT_RST = 16'h0000;
    // mode field encodings
    typedef enum logic [3:0] {
        ECP_OFF = 4'b0000,
        ECP_R01 = 4'b0001,
        ECP_R02 = 4'b0010,
        ECP_R03 = 4'b0011,
        ECP_CAP_FALL = 4'b0100,
        ECP_CAP_RISE = 4'b0101,
        ECP_CAP_RISE4 = 4'b0110,
        ECP_CAP_RISE16 = 4'b0111,
        ECP_CMP_SET = 4'b1000,
        ECP_CMP_CLR = 4'b1001,
        ECP_CMP_FLAG = 4'b1010,
        ECP_CMP_FLAG2 = 4'b1011,
        ECP_PWM0 = 4'b1100,
        ECP_PWM1 = 4'b1101,
        ECP_PWM2 = 4'b1110,
        ECP_PWM3 = 4'b1111
    } ecp_mode_t;
    // steering and mode class encodings
    localparam logic [1:0] ECP_STEER_SINGLE = 2'b00;
    localparam logic [1:0] ECP_STEER_FWD = 2'b01;
    localparam logic [1:0] ECP_STEER_HALF = 2'b10;
    localparam logic [1:0] ECP_STEER_REV = 2'b11;
    localparam logic [1:0] ECP_CLASS_PWM = 2'b11;
    localparam logic [1:0] ECP_CLASS_CMP = 2'b10;
    localparam logic [1:0] ECP_CLASS_CAP = 2'b01;
endpackage

/* File: logic/ecp_capture_store.sv */
// holds the 16-bit capture/compare value pair
// assumes the writer never asserts both loads in one cycle with different intent;
// capture load wins over a bus write
`timescale 1ns/1ps
`default_nettype none
module ecp_capture_store (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // loads
    input wire logic capture_load,
    input wire logic [15:0] capture_data,
    input wire logic bus_load,
    input wire logic [15:0] bus_data,
    // stored value
    output logic [15:0] value
);
    import ecp_pkg::*;
    logic [15:0] next_value;

    always_comb begin
        next_value = value;
        if (capture_load) begin
            next_value = capture_data;
        end else if (bus_load) begin
            next_value = bus_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= ECP_CAPT_RST;
        end else begin
            value <= next_value;
        end
    end
endmodule
`default_nettype wire

/* File: logic/ecp_unit.sv */
// capture/compare/pwm control unit with apb register access
// assumes timer_count_pair is synchronous to pclk and the capture pin is already synchronised
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ecp_unit #(
    parameter bit FULL_BRIDGE = 1'b1
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture pin and timer resource
    input wire logic capture_pin,
    input wire logic [15:0] timer_count_pair,
    // bridge outputs, enable high while the unit owns the pin
    output logic output_a,
    output logic output_a_oe,
    output logic output_b,
    output logic output_b_oe,
    output logic output_c,
    output logic output_c_oe,
    output logic output_d,
    output logic output_d_oe,
    // interrupt request toward the core
    output logic capture_irq
);
    import ecp_pkg::*;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m[3:2] == ECP_CLASS_CAP);
    endfunction

    // active level of the pin right after the edge the mode waits for
    function automatic logic edge_level(input logic [3:0] m);
        edge_level = (m != ECP_CAP_FALL);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] ctrl, next_ctrl, duty_high_byte, next_duty_high_byte, period, next_period;
    logic [6:0] dead_band, next_dead_band, db_cnt, next_db_cnt;
    logic capture_irq_flag, next_capture_irq_flag, capture_irq_enable, next_capture_irq_enable;
    logic pin_prev, next_pin_prev, match_prev, next_match_prev, cmp_level, next_cmp_level;
    logic [3:0] presc, next_presc;
    logic [9:0] pwm_cnt, next_pwm_cnt;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq, pwm_q, next_pwm_q;
    logic next_a, next_a_oe, next_b, next_b_oe, next_c, next_c_oe, next_d, next_d_oe;

    ecp_mode_t mode;
    logic [1:0] steer;
    logic [9:0] duty10;
    logic setup, access, wr, mapped;
    logic wr_ctrl, wr_capt;
    logic pin_rise, pin_fall, cap_event, match, cmp_hit;
    logic db_done;
    logic [15:0] capture_value_pair;

    assign mode = ecp_mode_t'(ctrl[ECP_MODE_HI:ECP_MODE_LO]);
    assign steer = ctrl[ECP_STEER_HI:ECP_STEER_LO];
    assign duty10 = {duty_high_byte, ctrl[ECP_DUTY_HI:ECP_DUTY_LO]};
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign wr_ctrl = wr & (paddr == ECP_OFF_CTRL);
    assign wr_capt = wr & (paddr == ECP_OFF_CAPT);
    assign mapped = (paddr == ECP_OFF_CTRL) | (paddr == ECP_OFF_DUTY) |
        (paddr == ECP_OFF_CAPT) | (paddr == ECP_OFF_STAT) |
        (paddr == ECP_OFF_DEAD) | (paddr == ECP_OFF_PER);

    // ----------------------------------------
    // capture value pair
    // ----------------------------------------
    ecp_capture_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .capture_load(cap_event),
        .capture_data(timer_count_pair),
        .bus_load(wr_capt),
        .bus_data(pwdata[15:0]),
        .value(capture_value_pair)
    );

    // ----------------------------------------
    // capture and compare events
    // ----------------------------------------
    assign pin_rise = capture_pin & ~pin_prev;
    assign pin_fall = ~capture_pin & pin_prev;
    assign match = (ctrl[3:2] == ECP_CLASS_CMP) & (timer_count_pair == capture_value_pair);
    assign cmp_hit = match & ~match_prev;

    always_comb begin
        cap_event = 1'b0;
        unique case (mode)
            ECP_CAP_FALL: cap_event = pin_fall;
            ECP_CAP_RISE: cap_event = pin_rise;
            ECP_CAP_RISE4: cap_event = pin_rise & (presc[1:0] == 2'b11);
            ECP_CAP_RISE16: cap_event = pin_rise & (presc == 4'hf);
            ECP_OFF, ECP_R01, ECP_R02, ECP_R03, ECP_CMP_SET, ECP_CMP_CLR, ECP_CMP_FLAG,
            ECP_CMP_FLAG2, ECP_PWM0, ECP_PWM1, ECP_PWM2, ECP_PWM3: cap_event = 1'b0;
        endcase
    end

    always_comb begin
        next_pin_prev = capture_pin;
        next_presc = presc;
        next_match_prev = match;
        next_cmp_level = cmp_level;
        if (is_capture(ctrl[3:0]) && pin_rise) begin
            next_presc = presc + 4'h1;
        end
        if (cmp_hit && mode == ECP_CMP_SET) begin
            next_cmp_level = 1'b1;
        end else if (cmp_hit && mode == ECP_CMP_CLR) begin
            next_cmp_level = 1'b0;
        end
        if (wr_ctrl && pwdata[3:0] != ctrl[3:0]) begin
            // the edge history is rearmed for the new mode; a pin already at the
            // new active level then reads as an edge and can set the flag
            next_presc = 4'h0;
            next_pin_prev = ~edge_level(pwdata[3:0]);
            next_cmp_level = 1'b0;
        end
    end

    // ----------------------------------------
    // pwm timebase and dead-band
    // ----------------------------------------
    always_comb begin
        next_pwm_cnt = pwm_cnt + 10'h001;
        if (pwm_cnt == {period, 2'b11}) begin
            next_pwm_cnt = 10'h000;
        end
        next_pwm_q = (pwm_cnt < duty10);
        next_db_cnt = db_cnt;
        if (next_pwm_q != pwm_q) begin
            next_db_cnt = 7'h00;
        end else if (db_cnt != 7'h7f) begin
            next_db_cnt = db_cnt + 7'h01;
        end
    end
    assign db_done = (db_cnt >= dead_band);

    // ----------------------------------------
    // output steering
    // ----------------------------------------
    always_comb begin
        {next_a, next_a_oe, next_b, next_b_oe} = 4'h0;
        {next_c, next_c_oe, next_d, next_d_oe} = 4'h0;
        if (ctrl[3:2] == ECP_CLASS_PWM) begin
            if (!FULL_BRIDGE) begin
                next_a_oe = 1'b1;
                next_a = pwm_q;
                if (steer[1]) begin
                    // complementary pair, each edge in held off by the dead-band
                    next_a = pwm_q & db_done;
                    next_b = ~pwm_q & db_done;
                    next_b_oe = 1'b1;
                end
            end else begin
                unique case (steer)
                    ECP_STEER_SINGLE: begin
                        next_a_oe = 1'b1;
                        next_a = pwm_q;
                    end
                    ECP_STEER_FWD: begin
                        next_a_oe = 1'b1;
                        next_b_oe = 1'b1;
                        next_c_oe = 1'b1;
                        next_d_oe = 1'b1;
                        next_a = 1'b1;
                        next_d = pwm_q;
                    end
                    ECP_STEER_HALF: begin
                        next_a_oe = 1'b1;
                        next_b_oe = 1'b1;
                        next_a = pwm_q & db_done;
                        next_b = ~pwm_q & db_done;
                    end
                    ECP_STEER_REV: begin
                        // mirror of forward drive
                        next_a_oe = 1'b1;
                        next_b_oe = 1'b1;
                        next_c_oe = 1'b1;
                        next_d_oe = 1'b1;
                        next_c = 1'b1;
                        next_b = pwm_q;
                    end
                endcase
            end
        end else if (ctrl[3:2] == ECP_CLASS_CMP) begin
            next_a_oe = 1'b1;
            next_a = cmp_level;
        end
    end

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_duty_high_byte = duty_high_byte;
        next_period = period;
        next_dead_band = dead_band;
        next_capture_irq_enable = capture_irq_enable;
        next_capture_irq_flag = capture_irq_flag;
        if (wr_ctrl) begin
            next_ctrl = pwdata[7:0];
        end
        if (wr && paddr == ECP_OFF_DUTY) begin
            next_duty_high_byte = pwdata[7:0];
        end
        if (wr && paddr == ECP_OFF_PER) begin
            next_period = pwdata[7:0];
        end
        if (wr && paddr == ECP_OFF_DEAD) begin
            next_dead_band = pwdata[6:0];
        end
        if (wr && paddr == ECP_OFF_STAT) begin
            next_capture_irq_enable = pwdata[ECP_STAT_IEN];
            if (pwdata[ECP_STAT_FLAG]) begin
                next_capture_irq_flag = 1'b0;
            end
        end
        // a new event in the clearing cycle is kept
        if (cap_event || cmp_hit) begin
            next_capture_irq_flag = 1'b1;
        end
        next_irq = next_capture_irq_flag & next_capture_irq_enable;
        next_pready = setup;
        next_pslverr = setup & ~mapped;
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            case (paddr)
                ECP_OFF_CTRL: next_prdata = {24'h00_0000, ctrl};
                ECP_OFF_DUTY: next_prdata = {24'h00_0000, duty_high_byte};
                ECP_OFF_CAPT: next_prdata = {16'h0000, capture_value_pair};
                ECP_OFF_STAT: next_prdata = {30'h0000_0000, capture_irq_enable, capture_irq_flag};
                ECP_OFF_DEAD: next_prdata = {25'h000_0000, dead_band};
                ECP_OFF_PER: next_prdata = {24'h00_0000, period};
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ctrl, duty_high_byte, period} <= {ECP_CTRL_RST, ECP_DUTY_RST, ECP_PER_RST};
            dead_band <= ECP_DEAD_RST;
            {capture_irq_flag, capture_irq_enable, capture_irq} <= 3'h0;
            {pin_prev, match_prev, cmp_level, pwm_q} <= 4'h0;
            {presc, pwm_cnt, db_cnt} <= 21'h00_0000;
            {prdata, pready, pslverr} <= 34'h0_0000_0000;
            {output_a, output_a_oe, output_b, output_b_oe} <= 4'h0;
            {output_c, output_c_oe, output_d, output_d_oe} <= 4'h0;
        end else begin
            {ctrl, duty_high_byte, period} <= {next_ctrl, next_duty_high_byte, next_period};
            dead_band <= next_dead_band;
            capture_irq_flag <= next_capture_irq_flag;
            capture_irq_enable <= next_capture_irq_enable;
            capture_irq <= next_irq;
            {pin_prev, match_prev} <= {next_pin_prev, next_match_prev};
            {cmp_level, pwm_q} <= {next_cmp_level, next_pwm_q};
            {presc, pwm_cnt, db_cnt} <= {next_presc, next_pwm_cnt, next_db_cnt};
            {prdata, pready, pslverr} <= {next_prdata, next_pready, next_pslverr};
            {output_a, output_a_oe} <= {next_a, next_a_oe};
            {output_b, output_b_oe} <= {next_b, next_b_oe};
            {output_c, output_c_oe} <= {next_c, next_c_oe};
            {output_d, output_d_oe} <= {next_d, next_d_oe};
        end
    end
endmodule
`default_nettype wire

/* File: sim/ecp_bridge_model.sv */
// bridge driver stand-in: turns the unit's pin levels and enables into pad levels
// assumes each released pad has a pull-down on the board
`timescale 1ns/1ps
`default_nettype none
module ecp_bridge_model (
    // unit side
    input wire logic output_a,
    input wire logic output_a_oe,
    input wire logic output_b,
    input wire logic output_b_oe,
    input wire logic output_c,
    input wire logic output_c_oe,
    input wire logic output_d,
    input wire logic output_d_oe,
    // pad levels seen by the driver stage
    output logic pad_a,
    output logic pad_b,
    output logic pad_c,
    output logic pad_d
);
    // a released pad sits at the pull-down level, never at the last driven value
    assign pad_a = output_a_oe ? output_a : 1'b0;
    assign pad_b = output_b_oe ? output_b : 1'b0;
    assign pad_c = output_c_oe ? output_c : 1'b0;
    assign pad_d = output_d_oe ? output_d : 1'b0;
endmodule
`default_nettype wire

/* File: sim/ecp_unit_sva.sv */
// port-level checker for the capture/pwm control unit
// assumes zero-wait apb and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ecp_unit_sva #(
    parameter bit FULL_BRIDGE = 1'b1
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // capture side
    input wire logic capture_pin,
    input wire logic [15:0] timer_count_pair,
    // bridge outputs
    input wire logic output_a,
    input wire logic output_a_oe,
    input wire logic output_b,
    input wire logic output_b_oe,
    input wire logic output_c,
    input wire logic output_c_oe,
    input wire logic output_d,
    input wire logic output_d_oe,
    input wire logic capture_irq
);
    // ----------------------------------------
    // shadow of the written control state
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic [6:0] dead_q;
    logic [2:0] sc;
    logic seen;
    wire logic acc = psel && penable && pready;
    wire logic wr_st = acc && pwrite && paddr == 8'h0c;
    wire logic rd_st = acc && !pwrite && paddr == 8'h0c;
    // outputs lag a mode write by a few cycles, so judge only settled states
    wire logic pwm = ctrl_q[3:2] == 2'b11 && sc == 3'd7;
    wire logic nopwm = ctrl_q[3:2] != 2'b11 && sc == 3'd7;
    wire logic [1:0] st = ctrl_q[7:6];
    wire logic half = FULL_BRIDGE ? st == 2'b10 : st[1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 8'h00;
            dead_q <= 7'h00;
            sc <= 3'd7;
            seen <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == 8'h00) begin
                ctrl_q <= pwdata[7:0];
                sc <= 3'd0;
            end else if (sc != 3'd7) begin
                sc <= sc + 3'd1;
            end
            if (acc && pwrite && paddr == 8'h10) begin
                dead_q <= pwdata[6:0];
            end
            if (wr_st && pwdata[0]) begin
                seen <= 1'b0;
            end else if (rd_st && prdata[0]) begin
                seen <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_cap_release: assert property (
        nopwm |-> !output_b_oe && !output_c_oe && !output_d_oe)
        else $error("port pins driven outside pwm");
    a_steer_applies: assert property (
        pwm && (FULL_BRIDGE ? st != 2'b00 : st[1]) |-> output_b_oe)
        else $error("steering ignored in pwm");
    a_single_out: assert property (
        pwm && (FULL_BRIDGE ? st == 2'b00 : !st[1])
        |-> output_a_oe && !output_b_oe && !output_c_oe && !output_d_oe)
        else $error("single output mode drives wrong pins");
    a_fwd_drive: assert property (
        FULL_BRIDGE && pwm && st == 2'b01 |-> output_a && !output_b && !output_c
        && output_a_oe && output_b_oe && output_c_oe && output_d_oe)
        else $error("forward drive levels wrong");
    a_half_pins: assert property (
        FULL_BRIDGE && pwm && st == 2'b10 |-> !output_c_oe && !output_d_oe)
        else $error("half bridge drives c or d");
    a_no_overlap: assert property (
        pwm && half |-> !(output_a && output_b))
        else $error("complementary outputs overlap");
    a_dead_gap: assert property (
        pwm && half && dead_q == 7'h02 && $fell(output_a) |-> !output_b ##1 !output_b)
        else $error("dead band too short");
    a_flag_sticky: assert property (
        rd_st && seen |-> prdata[0])
        else $error("capture flag dropped without a clear");
    c_fwd: cover property (FULL_BRIDGE && pwm && st == 2'b01);
    c_dead: cover property (pwm && half && $fell(output_a));
    c_slverr: cover property (acc && pslverr);
endmodule
bind ecp_unit ecp_unit_sva #(.FULL_BRIDGE(FULL_BRIDGE)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .timer_count_pair(timer_count_pair),
    .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
    .output_b_oe(output_b_oe), .output_c(output_c), .output_c_oe(output_c_oe),
    .output_d(output_d), .output_d_oe(output_d_oe), .capture_irq(capture_irq));
`default_nettype wire

/* File: sim/enhanced_capture_pwm_control_test.sv */
// self-checking bench for the capture/pwm control unit
// assumes a full-bridge uut beside a half-bridge twin, zero-wait apb and a 40 MHz pclk
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module enhanced_capture_pwm_control_test;
    typedef struct {logic [7:0] ctrl; logic [3:0] oe; logic [7:0] na;} ecp_row_t;
    logic pclk, presetn, psel, penable, pwrite, capture_pin, capture_irq, pready, pslverr, er;
    logic [7:0] paddr, ca, cb, ov, cd;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] tim;
    logic output_a, output_a_oe, output_b, output_b_oe, output_c, output_c_oe;
    logic output_d, output_d_oe, pad_a, pad_b, pad_c, pad_d;
    int err_count, checks;
    wire logic [3:0] oes = {output_a_oe, output_b_oe, output_c_oe, output_d_oe};
    wire logic [7:0] hp;
    wire logic [3:0] hoes = {hp[6], hp[4], hp[2], hp[0]};
    // period 2 and duty high 1 give a 12-cycle frame with a base duty of 4
    ecp_row_t rows[] = '{'{8'h0c, 4'h8, 8'd4}, '{8'h1c, 4'h8, 8'd5}, '{8'h2c, 4'h8, 8'd6},
        '{8'h3c, 4'h8, 8'd7}, '{8'h4c, 4'hf, 8'd12}, '{8'h8c, 4'hc, 8'd4},
        '{8'hcc, 4'hf, 8'd0}, '{8'h44, 4'h0, 8'hff}, '{8'h85, 4'h0, 8'hff},
        '{8'hc6, 4'h0, 8'hff}, '{8'h47, 4'h0, 8'hff}, '{8'h48, 4'h8, 8'hff},
        '{8'h89, 4'h8, 8'hff}, '{8'hca, 4'h8, 8'hff}, '{8'h0b, 4'h8, 8'hff},
        '{8'hc0, 4'h0, 8'hff}};
    ecp_unit #(.FULL_BRIDGE(1'b1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pin(capture_pin), .timer_count_pair(tim), .output_a(output_a),
        .output_a_oe(output_a_oe), .output_b(output_b), .output_b_oe(output_b_oe),
        .output_c(output_c), .output_c_oe(output_c_oe), .output_d(output_d),
        .output_d_oe(output_d_oe), .capture_irq(capture_irq));
    // half-bridge twin on the same bus and pin, so the half-bridge steering is exercised
    ecp_unit #(.FULL_BRIDGE(1'b0)) uut_half (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .capture_pin(capture_pin), .timer_count_pair(tim), .output_a(hp[7]),
        .output_a_oe(hp[6]), .output_b(hp[5]), .output_b_oe(hp[4]), .output_c(hp[3]),
        .output_c_oe(hp[2]), .output_d(hp[1]), .output_d_oe(hp[0]), .capture_irq());
    ecp_bridge_model drv (
        .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
        .output_b_oe(output_b_oe), .output_c(output_c), .output_c_oe(output_c_oe),
        .output_d(output_d), .output_d_oe(output_d_oe),
        .pad_a(pad_a), .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----------------------------------------
    // bus and measurement tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read_data", e, rd)
    endtask
    task automatic count(input int n);
        ca = 8'h00;
        cb = 8'h00;
        ov = 8'h00;
        cd = 8'h00;
        repeat (n) begin
            @(posedge pclk);
            ca = ca + {7'h00, pad_a};
            cb = cb + {7'h00, pad_b};
            ov = ov + {7'h00, pad_a & pad_b};
            cd = cd + {7'h00, pad_d};
        end
    endtask
    task automatic pulse();
        capture_pin <= 1'b1;
        repeat (2) @(posedge pclk);
        capture_pin <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, presetn, capture_pin} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        tim = 16'h0000; // timer steps only from a slow source, never per pclk
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wr(8'h14, 32'h2);
        wr(8'h04, 32'h1);
        foreach (rows[i]) begin
            wr(8'h00, {24'h0, rows[i].ctrl});
            repeat (16) @(posedge pclk);
            `CHK("pin_enables", rows[i].oe, oes)
            if (rows[i].na != 8'hff) begin
                count(12);
                `CHK("a_high_cycles", rows[i].na, ca)
            end
            $display("row %0d done", i);
        end
        wr(8'h10, 32'h2);
        wr(8'h00, 32'hac);
        repeat (16) @(posedge pclk);
        count(12);
        `CHK("a_dead", 8'd4, ca)
        `CHK("b_dead", 8'd4, cb)
        `CHK("overlap", 8'd0, ov)
        `CHK("half_pair_oe", 4'hc, hoes)
        $display("dead band test done");
        wr(8'h00, 32'h6c);
        repeat (16) @(posedge pclk);
        count(12);
        `CHK("d_forward", 8'd6, cd)
        `CHK("half_single_oe", 4'h8, hoes)
        $display("forward and single output test done");
        apb(1'b0, 8'h18, 32'h0);
        `CHK("slverr", 1'b1, er)
        `CHK("unmapped_data", 32'h0, rd)
        $display("unmapped test done");
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h05);
        wr(8'h0c, 32'h1);
        tim <= 16'h1234;
        capture_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(8'h08, 32'h1234);
        rdc(8'h0c, 32'h1);
        tim <= 16'h5678;
        pulse();
        capture_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(8'h08, 32'h5678);
        rdc(8'h0c, 32'h1);
        wr(8'h0c, 32'h2);
        repeat (2) @(posedge pclk);
        `CHK("irq_on", 1'b1, capture_irq)
        wr(8'h0c, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK("irq_off", 1'b0, capture_irq)
        wr(8'h0c, 32'h0);
        wr(8'h00, 32'h04);
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'h05);
        repeat (3) @(posedge pclk);
        rdc(8'h0c, 32'h1);
        capture_pin <= 1'b0;
        wr(8'h00, 32'h06);
        wr(8'h0c, 32'h1);
        for (int k = 1; k <= 4; k++) begin
            pulse();
            apb(1'b0, 8'h0c, 32'h0);
            `CHK("every_4th", 1'(k == 4), rd[0])
        end
        $display("capture test done");
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h0);
        rdc(8'h0c, 32'h0);
        rdc(8'h10, 32'h0);
        rdc(8'h14, 32'hff);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
